// ### edh_host_defs.svh
// Constants for the parallel host port of the EDH coprocessor.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EDH_HOST_DEFS_SVH
`define EDH_HOST_DEFS_SVH

// ****************************************************************
// Table geometry
// ****************************************************************
`define BYTE_W          8
`define WR_FIRST_ADDR   8'h01
`define WR_LAST_ADDR    8'h0f
`define WR_COUNT        15
`define RD_COUNT        23
`define RD_LAST_ADDR    8'h16
`define WR_FLAT_W       120
`define RD_FLAT_W       184
`define PTR_RESET       8'h00
`define PTR_STEP        8'h01
`define BYTE_ZERO       8'h00

// ****************************************************************
// Write table defaults, address 15 in the top byte, address 1 lowest
// ****************************************************************
`define WR_DEFAULTS_FLAT 120'h18_00_00_00_00_00_01_00_00_00_00_00_44_40_00

// ****************************************************************
// Internal power-on reset
// ****************************************************************
`define POR_W           4
`define POR_ZERO        4'h0
`define POR_DONE_COUNT  4'hf
`define POR_STEP        4'h1

`endif

// ### edh_host_pkg.sv
// Types shared by the parallel host port modules.
// Assumes edh_host_defs.svh is on the include path.
`include "edh_host_defs.svh"

package edh_host_pkg;

    // Kind of host cycle seen at a chip-select falling edge
    typedef enum logic [1:0]
    {
        CYC_NONE,
        CYC_ADDR,
        CYC_WRITE,
        CYC_READ
    } cyc_kind_t;

    typedef logic [`BYTE_W-1:0] host_byte_t;

endpackage

// ### edh_parallel_host_port.sv
// Parallel host port of the EDH coprocessor: multiplexed address/data bus,
// pointer with auto-increment, write table and status snapshot table.
// Assumes host pins are synchronous to CLK_SYS_I and held stable around
// the chip-select falling edge; the bus wire is resolved outside.
//
// Summary of operation
// - One 8-bit shared address/data bus with chip select, read/write, address/data select.
// - Host cycles never depend on the video pixel clock.
// - Every transfer is taken or launched at the chip-select falling edge.
// - Bus driven only while chip select low and read/write high, combinationally.
// - Write with address select high loads the pointer.
// - Write with address select low stores the byte at the pointer.
// - Read edge places the byte at the pointer on the bus.
// - Pointer advances by one after each data transfer.
// - Any address cycle replaces the incremented pointer.
// - Reads return the values of the most recently received packet.
// - Writes take effect in the packet of the following field.
// - Reset reinitialises control logic and restores every write table default.
// - Reset leaves the video datapath passing data.
// - An internal power-on reset also initialises the port.
// - Write table of 15 bytes, status table of 23 bytes.
// - Port active only while the interface-select pin is low.
`timescale 1ns/10ps
`default_nettype none
`include "edh_host_defs.svh"

module edh_parallel_host_port
    import edh_host_pkg::*;
(
    // Clock and reset
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RESET_I,
    // Interface selection, low selects this parallel port
    input  wire logic                  HOST_PORT_SELECT_I,
    // Host pins
    input  wire logic                  CS_N_I,
    input  wire logic                  RW_I,
    input  wire logic                  AD_I,
    input  wire logic [`BYTE_W-1:0]    P_I,
    output logic      [`BYTE_W-1:0]    P_O,
    output logic                       P_OE_O,
    // Status from the EDH datapath
    input  wire logic [`RD_FLAT_W-1:0] STATUS_I,
    input  wire logic                  STATUS_LATCH_I,
    // Configuration to the EDH datapath
    input  wire logic                  CONFIG_LATCH_I,
    output logic      [`WR_FLAT_W-1:0] CONFIG_O
);

    // ****************************************************************
    // Internal power-on reset
    // ****************************************************************
    // Relies on the register initialiser, which FPGA flows honour; the
    // external reset is still needed where the supply rises slowly.
    logic [`POR_W-1:0] por_cnt_reg = `POR_ZERO;
    logic [`POR_W-1:0] por_cnt_next;
    logic              por_done;
    logic              int_rst;

    always_comb
    begin
        por_done     = (por_cnt_reg == `POR_DONE_COUNT);
        por_cnt_next = por_done ? por_cnt_reg : por_cnt_reg + `POR_STEP;
        // Reset clears only host-side state; nothing here gates the video path
        int_rst      = RESET_I | ~por_done;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        por_cnt_reg <= por_cnt_next;
    end

    // ****************************************************************
    // Cycle decode at the chip-select falling edge
    // ****************************************************************
    // Only the chip-select edge matters; levels alone never act, so the
    // pixel clock plays no part in any host cycle.
    logic       cs_n_prev_reg;
    logic       cs_n_prev_next;
    logic       cs_fall;
    cyc_kind_t  cyc_kind;

    always_comb
    begin
        cs_n_prev_next = CS_N_I;
        cs_fall        = cs_n_prev_reg & ~CS_N_I & ~HOST_PORT_SELECT_I;
        cyc_kind       = CYC_NONE;
        if (cs_fall)
        begin
            if (RW_I)
            begin
                cyc_kind = CYC_READ;
            end
            else if (AD_I)
            begin
                cyc_kind = CYC_ADDR;
            end
            else
            begin
                cyc_kind = CYC_WRITE;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (int_rst)
        begin
            cs_n_prev_reg <= 1'b1;
        end
        else
        begin
            cs_n_prev_reg <= cs_n_prev_next;
        end
    end

    // ****************************************************************
    // Status snapshot table
    // ****************************************************************
    host_byte_t rd_table_reg [0:`RD_COUNT-1];
    host_byte_t rd_table_next [0:`RD_COUNT-1];

    // Snapshot at packet arrival so that reads in the safe window show the
    // previous field's packet even while new data streams in.
    always_comb
    begin
        for (int i = 0; i < `RD_COUNT; i++)
        begin
            rd_table_next[i] = STATUS_LATCH_I ? STATUS_I[i*`BYTE_W +: `BYTE_W] : rd_table_reg[i];
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        for (int i = 0; i < `RD_COUNT; i++)
        begin
            if (int_rst)
            begin
                rd_table_reg[i] <= `BYTE_ZERO;
            end
            else
            begin
                rd_table_reg[i] <= rd_table_next[i];
            end
        end
    end

    // ****************************************************************
    // Pointer and read data
    // ****************************************************************
    host_byte_t ptr_reg;
    host_byte_t ptr_next;
    host_byte_t rd_byte;
    host_byte_t p_out_reg;
    host_byte_t p_out_next;

    always_comb
    begin
        ptr_next   = ptr_reg;
        p_out_next = p_out_reg;
        rd_byte    = (ptr_reg <= `RD_LAST_ADDR) ? rd_table_reg[ptr_reg[4:0]] : `BYTE_ZERO;
        unique case (cyc_kind)
            CYC_NONE:
            begin
                ptr_next = ptr_reg;
            end
            CYC_ADDR:
            begin
                ptr_next = P_I;
            end
            CYC_WRITE:
            begin
                ptr_next = ptr_reg + `PTR_STEP;
            end
            CYC_READ:
            begin
                p_out_next = rd_byte;
                ptr_next   = ptr_reg + `PTR_STEP;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (int_rst)
        begin
            ptr_reg   <= `PTR_RESET;
            p_out_reg <= `BYTE_ZERO;
        end
        else
        begin
            ptr_reg   <= ptr_next;
            p_out_reg <= p_out_next;
        end
    end

    assign P_O = p_out_reg;
    // Enable follows the pins directly, as the host expects release times
    // measured from the pins, not from a clock edge.
    assign P_OE_O = ~CS_N_I & RW_I & ~HOST_PORT_SELECT_I;

    // ****************************************************************
    // Write table
    // ****************************************************************
    localparam logic [`WR_FLAT_W-1:0] WR_DEFAULTS = `WR_DEFAULTS_FLAT;

    logic [`WR_FLAT_W-1:0] working_flat;

    for (genvar k = 0; k < `WR_COUNT; k++)
    begin : g_wr
        logic wr_hit;
        assign wr_hit = (cyc_kind == CYC_WRITE) && (ptr_reg == 8'(k + 1));
        host_table_byte #(
            .DEFAULT_VALUE (WR_DEFAULTS[k*`BYTE_W +: `BYTE_W])
        ) u_byte (
            .clk_i     (CLK_SYS_I),
            .rst_i     (int_rst),
            .load_i    (wr_hit),
            .data_i    (P_I),
            .working_o (working_flat[k*`BYTE_W +: `BYTE_W]),
            .apply_i   (CONFIG_LATCH_I),
            .applied_o (CONFIG_O[k*`BYTE_W +: `BYTE_W])
        );
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    addr_load_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cs_fall && !RW_I && AD_I) |=> (ptr_reg == $past(P_I)))
        else $error("Address cycle did not load the pointer");

    ptr_step_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cs_fall && (RW_I || !AD_I)) |=> (ptr_reg == $past(ptr_reg) + `PTR_STEP))
        else $error("Pointer did not advance after a data cycle");

    read_launch_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cs_fall && RW_I) |=> (P_O == $past(rd_byte)))
        else $error("Read cycle did not place the pointed byte on the bus");

    bus_release_a: assert property (@(posedge CLK_SYS_I)
        (CS_N_I || !RW_I) |-> !P_OE_O)
        else $error("Bus driven outside a read with chip select low");

    idle_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (CS_N_I && $past(CS_N_I)) |=> ($stable(ptr_reg) && $stable(working_flat)))
        else $error("State changed while chip select was high");

    serial_mode_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        HOST_PORT_SELECT_I |=> ($stable(ptr_reg) && $stable(working_flat) && !$past(P_OE_O)))
        else $error("Parallel port acted while the serial interface was selected");

    reset_default_a: assert property (@(posedge CLK_SYS_I)
        RESET_I |=> (CONFIG_O == WR_DEFAULTS && working_flat == WR_DEFAULTS && ptr_reg == `PTR_RESET))
        else $error("Reset did not restore table defaults");

    status_snap_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (STATUS_LATCH_I ##1 !STATUS_LATCH_I) |=> (rd_table_reg[1] == $past(STATUS_I[15:8], 2)))
        else $error("Status table did not hold the latched packet values");

    config_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        !CONFIG_LATCH_I |=> $stable(CONFIG_O))
        else $error("Configuration changed outside the field boundary");

    por_hold_a: assert property (@(posedge CLK_SYS_I)
        !por_done |=> (P_O == `BYTE_ZERO && ptr_reg == `PTR_RESET))
        else $error("Power-on reset not holding the port");

    edge_only_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        !cs_fall |=> $stable(ptr_reg))
        else $error("Pointer moved without a chip-select falling edge");

    write_store_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cyc_kind == CYC_WRITE && ptr_reg == `WR_FIRST_ADDR) |=> (working_flat[`BYTE_W-1:0] == $past(P_I)))
        else $error("Data cycle did not store the byte at the pointer");

    write_skip_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cyc_kind == CYC_WRITE && (ptr_reg < `WR_FIRST_ADDR || ptr_reg > `WR_LAST_ADDR)) |=> $stable(working_flat))
        else $error("Write outside the table changed a stored byte");

    read_drive_a: assert property (@(posedge CLK_SYS_I)
        (!CS_N_I && RW_I && !HOST_PORT_SELECT_I) |-> P_OE_O)
        else $error("Bus not driven during a read with chip select low");

    read_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        !(cs_fall && RW_I) |=> $stable(P_O))
        else $error("Read data changed without a read cycle");

    read_beyond_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        (cs_fall && RW_I && ptr_reg > `RD_LAST_ADDR) |=> (P_O == `BYTE_ZERO))
        else $error("Read beyond the status table returned data");

    status_load_a: assert property (@(posedge CLK_SYS_I) disable iff (int_rst)
        STATUS_LATCH_I |=> (rd_table_reg[0] == $past(STATUS_I[`BYTE_W-1:0])))
        else $error("Status latch did not capture the first location");

endmodule

`default_nettype wire

// ### edh_parallel_host_port_test.sv
// Self-checking bench for the parallel host port.
// Assumes host_mcu_model.sv and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "edh_host_defs.svh"

module edh_parallel_host_port_test;
    import edh_host_pkg::*;

    logic                  clk;
    logic                  rst;
    logic                  sel;
    logic                  cs_n;
    logic                  rw;
    logic                  ad;
    host_byte_t            bus;
    host_byte_t            p_o;
    logic                  p_oe;
    logic [`RD_FLAT_W-1:0] status;
    logic [`RD_FLAT_W-1:0] snap;
    logic                  st_latch;
    logic                  cfg_latch;
    logic [`WR_FLAT_W-1:0] cfg;
    logic [`WR_FLAT_W-1:0] wt;
    host_byte_t            ptr;
    host_byte_t            q;
    logic [31:0]           seed;
    int                    failures;
    int                    total_checks;
    int                    cycles;

    edh_parallel_host_port dut (.CLK_SYS_I(clk), .RESET_I(rst), .HOST_PORT_SELECT_I(sel),
        .CS_N_I(cs_n), .RW_I(rw), .AD_I(ad), .P_I(bus), .P_O(p_o), .P_OE_O(p_oe),
        .STATUS_I(status), .STATUS_LATCH_I(st_latch), .CONFIG_LATCH_I(cfg_latch), .CONFIG_O(cfg));

    host_mcu_model host (.clk_i(clk), .cs_n_o(cs_n), .rw_o(rw), .ad_o(ad), .bus_o(bus),
        .dev_p_i(p_o), .dev_oe_i(p_oe));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ********
    // Helpers
    // ********
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string name, input logic [119:0] seen, input logic [119:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic a, input host_byte_t d);
        host.xfer(1'b0, a, d, q);
        if (a)
            ptr = d;
        else
        begin
            if (ptr >= 8'h01 && ptr <= 8'h0f)
                wt[8*(ptr-1) +: 8] = d;
            ptr++;
        end
    endtask

    task automatic rd();
        host.xfer(1'b1, 1'b0, 8'h00, q);
        check("read byte", 120'(q), (ptr <= 8'h16) ? 120'(snap[8*ptr +: 8]) : 120'h0);
        check("drive released", 120'(p_oe), 120'h0);
        ptr++;
    endtask

    // Latch pulse, then a settling edge before anything changes
    task automatic pulse(input logic st);
        st_latch = st;
        cfg_latch = ~st;
        @(posedge clk);
        #1;
        st_latch = 1'b0;
        cfg_latch = 1'b0;
        @(posedge clk);
        #1;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            end_of_test();
        end
    end

    // ********
    // Scenarios
    // ********
    initial
    begin
        seed = 32'd57464;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        rst = 1'b1;
        sel = 1'b0;
        status = '0;
        snap = '0;
        st_latch = 1'b0;
        cfg_latch = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        wt = `WR_DEFAULTS_FLAT;
        ptr = 8'h00;
        check("config defaults", cfg, wt);
        check("read idle", 120'(p_o), 120'h0);
        check("drive idle", 120'(p_oe), 120'h0);
        // Address 0 and 16 store nothing; 1..15 filled by increment
        wr(1'b1, 8'h00);
        repeat (17) wr(1'b0, 8'(rnd()));
        check("config before latch", cfg, `WR_DEFAULTS_FLAT);
        repeat (6) host.noise(8'(rnd()));
        pulse(1'b0);
        check("config sequential", cfg, wt);
        repeat (12)
        begin
            wr(1'b1, 8'(rnd() % 15 + 1));
            wr(1'b0, 8'(rnd()));
        end
        pulse(1'b0);
        check("config random", cfg, wt);
        for (int i = 0; i < 5; i++)
            status[32*i +: 32] = rnd();
        status[183:160] = 24'(rnd());
        pulse(1'b1);
        snap = status;
        status = ~status;
        // Host traffic sits between the status and config latches
        wr(1'b1, 8'h00);
        repeat (24) rd();
        repeat (20)
        begin
            wr(1'b1, 8'(rnd() % 24));
            rd();
        end
        sel = 1'b1;
        host.xfer(1'b0, 1'b1, 8'h02, q);
        host.xfer(1'b0, 1'b0, 8'ha5, q);
        sel = 1'b0;
        pulse(1'b0);
        check("config deselected", cfg, wt);
        rst = 1'b1;
        repeat (25) @(posedge clk);
        #1;
        rst = 1'b0;
        check("config rereset", cfg, `WR_DEFAULTS_FLAT);
        check("read rereset", 120'(p_o), 120'h0);
        snap = '0;
        ptr = 8'h00;
        rd();
        end_of_test();
    end
endmodule
`default_nettype wire

// ### host_mcu_model.sv
// Host microcontroller model driving the multiplexed address/data bus.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module host_mcu_model
    import edh_host_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Host pins
    output logic            cs_n_o,
    output logic            rw_o,
    output logic            ad_o,
    output host_byte_t      bus_o,
    // Device drive
    input  wire host_byte_t dev_p_i,
    input  wire logic       dev_oe_i
);
    logic       drive_reg;
    host_byte_t data_reg;
    host_byte_t last_reg;

    initial
    begin
        cs_n_o = 1'b1;
        rw_o = 1'b1;
        ad_o = 1'b0;
        drive_reg = 1'b0;
        data_reg = 8'h00;
        last_reg = 8'h00;
    end

    // ********
    // Bus wire
    // ********
    // A released bus flips every cycle so a stale byte never reads as valid
    always_comb
    begin
        if (dev_oe_i)
            bus_o = dev_p_i;
        else if (drive_reg)
            bus_o = data_reg;
        else
            bus_o = ~last_reg;
    end

    always @(posedge clk_i)
        last_reg <= bus_o;

    // One strobe: pins held across the sampling edge, then chip select raised
    task automatic xfer(input logic rw, input logic ad, input host_byte_t d, output host_byte_t q);
        cs_n_o = 1'b0;
        rw_o = rw;
        ad_o = ad;
        data_reg = d;
        drive_reg = ~rw;
        @(posedge clk_i);
        #1;
        q = bus_o;
        cs_n_o = 1'b1;
        drive_reg = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    // Pin activity with chip select high
    task automatic noise(input host_byte_t d);
        rw_o = d[0];
        ad_o = d[1];
        data_reg = d;
        drive_reg = ~d[0];
        @(posedge clk_i);
        #1;
        drive_reg = 1'b0;
        rw_o = 1'b1;
        @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// ### host_table_byte.sv
// One location of the host write table: a working byte that the host
// writes and an applied byte that the datapath uses for the next packet.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "edh_host_defs.svh"

module host_table_byte
    import edh_host_pkg::*;
#(
    parameter host_byte_t DEFAULT_VALUE = `BYTE_ZERO
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Host side
    input  wire logic       load_i,
    input  wire host_byte_t data_i,
    output host_byte_t      working_o,
    // Datapath side
    input  wire logic       apply_i,
    output host_byte_t      applied_o
);

    host_byte_t working_reg;
    host_byte_t working_next;
    host_byte_t applied_reg;
    host_byte_t applied_next;

    // A host write never reaches the packet already being built: the
    // applied copy only takes the working copy at the field boundary.
    always_comb
    begin
        working_next = working_reg;
        applied_next = applied_reg;
        if (load_i)
        begin
            working_next = data_i;
        end
        if (apply_i)
        begin
            applied_next = working_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            working_reg <= DEFAULT_VALUE;
            applied_reg <= DEFAULT_VALUE;
        end
        else
        begin
            working_reg <= working_next;
            applied_reg <= applied_next;
        end
    end

    assign working_o = working_reg;
    assign applied_o = applied_reg;

    apply_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (load_i && !apply_i) |=> (applied_o == $past(applied_o)))
        else $error("Host write reached the applied byte before the field boundary");

endmodule

`default_nettype wire
